// ---- ufi_fifo_isr.sv ----
// Purpose: fifo control register tail and prioritised interrupt status for one channel
// Assumes: wishbone classic slave, one system clock, fifo logic outside this block
// Notes: ack comes one cycle after the request is seen; unmapped reads return zero
//
// Our own choices: the Wishbone register port and the placing of the registers.
`default_nettype none
// Summary of operation
// [R1] rx fifo reset bit empties rx fifo
// [R2] shift register untouched; reset bit self-clears
// [R3] fifo enable bit gates both fifos
// [R4] other control bits load only with enable
// [R5] rx trigger codes give 8,16,24,28
// [R6] tx trigger codes give 16,8,24,30
// [R7] status read shows highest pending source only
// [R8] lower source hidden while higher pending
// [R9] codes for line, data, timeout, tx empty
// [R10] codes for modem, xoff, flow change
// [R11] top bits reflect fifo enable
// [R12] bits five, four need enhanced enable
// [R13] xoff bit holds until xon received
// [R14] bit five flags auto flow event
// [R15] bit zero low while interrupt pending
// [R16] rx interrupt at occupancy equal trigger
// [R17] tx interrupt when below trigger
// [R18] idle status reads zeros in bits five to one
module ufi_fifo_isr
  import ufi_pkg::*;
#(
  parameter int LVL_W = 6
) (
  input wire logic clock, // system clock, 125 MHz
  input wire logic arst_n, // async reset, active low
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // write enable
  input wire logic [4:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte lanes
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // acknowledge
  input wire logic [LVL_W-1:0] rx_level, // rx fifo occupancy
  input wire logic [LVL_W-1:0] tx_level, // tx fifo occupancy
  input wire logic line_status_source, // line error pending
  input wire logic rx_timeout, // receive timeout pending
  input wire logic modem_status_source, // modem change pending
  input wire logic xoff_seen, // matching xoff pulse
  input wire logic xon_seen, // matching xon pulse
  input wire logic flow_event, // auto cts/rts event pulse
  output logic fifo_enable, // both fifos enabled
  output logic rx_fifo_clear, // one-cycle rx fifo clear
  output logic [LVL_W-1:0] rx_trigger, // rx trigger in bytes
  output logic [LVL_W-1:0] tx_trigger, // tx trigger in bytes
  output logic [7:0] interrupt_status, // live status value
  output logic irq // level interrupt
);

  function automatic logic [LVL_W-1:0] rx_trig_f(input logic [1:0] c);
    unique case (c)
      2'b00: rx_trig_f = LVL_W'(UFI_RX_TRIG0);
      2'b01: rx_trig_f = LVL_W'(UFI_RX_TRIG1);
      2'b10: rx_trig_f = LVL_W'(UFI_RX_TRIG2);
      2'b11: rx_trig_f = LVL_W'(UFI_RX_TRIG3);
    endcase
  endfunction

  function automatic logic [LVL_W-1:0] tx_trig_f(input logic [1:0] c);
    unique case (c)
      2'b00: tx_trig_f = LVL_W'(UFI_TX_TRIG0);
      2'b01: tx_trig_f = LVL_W'(UFI_TX_TRIG1);
      2'b10: tx_trig_f = LVL_W'(UFI_TX_TRIG2);
      2'b11: tx_trig_f = LVL_W'(UFI_TX_TRIG3);
    endcase
  endfunction

  ufi_state_t s_q, s_d;
  logic fen, efen, rx_hit, tx_low;
  logic [UFI_NEV-1:0] live, ev_set;
  logic [5:0] code;
  logic [7:0] isr_val;
  logic req, wr;

  assign fen = s_q.fctl[UFI_FEN_BIT];
  assign efen = s_q.enhanced_feature_reg[UFI_EFEN_BIT];
  assign rx_trigger = rx_trig_f(s_q.fctl[7:6]); // see [R5]
  assign tx_trigger = tx_trig_f(s_q.fctl[5:4]); // see [R6]
  assign rx_hit = fen && (rx_level == rx_trigger); // see [R16]
  assign tx_low = tx_level < tx_trigger; // see [R17]
  assign fifo_enable = fen; // see [R3]
  assign rx_fifo_clear = s_q.rx_clr; // see [R1]

  // live sources; xoff/flow only exist with enhanced features on
  always_comb begin
    live = '0;
    live[UFI_EV_LSR] = line_status_source;
    live[UFI_EV_RXD] = rx_hit;
    live[UFI_EV_RTO] = rx_timeout;
    live[UFI_EV_THR] = tx_low;
    live[UFI_EV_MSR] = modem_status_source;
    live[UFI_EV_XOFF] = efen && s_q.xoff_hold; // see [R12]
    live[UFI_EV_FLOW] = efen && s_q.evst[UFI_EV_FLOW]; // see [R14]
  end

  // priority encoder: first true branch wins, so lower levels stay hidden
  always_comb begin
    code = UFI_CODE_MSR;
    if (live[UFI_EV_LSR]) begin
      code = UFI_CODE_LSR; // see [R7] see [R9]
    end else if (live[UFI_EV_RTO]) begin
      code = UFI_CODE_RTO; // see [R9]
    end else if (live[UFI_EV_RXD]) begin
      code = UFI_CODE_RXD; // see [R9]
    end else if (live[UFI_EV_THR]) begin
      code = UFI_CODE_THR; // see [R8] see [R9]
    end else if (live[UFI_EV_MSR]) begin
      code = UFI_CODE_MSR; // see [R10]
    end else if (live[UFI_EV_XOFF]) begin
      code = UFI_CODE_XOFF; // see [R10] see [R13]
    end else if (live[UFI_EV_FLOW]) begin
      code = UFI_CODE_FLOW; // see [R10]
    end
    isr_val = {{2{fen}}, code[5:1], ~(|live)}; // see [R11] see [R15] see [R18]
    if (!(|live)) begin
      isr_val[5:1] = '0; // see [R18]
    end
  end
  assign interrupt_status = isr_val;

  assign req = wb_cyc_i && wb_stb_i && !s_q.ack;
  assign wr = req && wb_we_i;
  assign wb_ack_o = s_q.ack;
  assign wb_dat_o = s_q.dat;
  assign irq = |(s_q.evst & s_q.evmsk);

  always_comb begin
    s_d = s_q;
    s_d.ack = req;
    s_d.rx_clr = 1'b0; // see [R2]
    // flow flag here is sticky inside live too, so take it from the flow_event pulse
    ev_set = live;
    ev_set[UFI_EV_FLOW] = flow_event;
    ev_set[UFI_EV_XOFF] = xoff_seen;
    if (xoff_seen) begin
      s_d.xoff_hold = 1'b1; // see [R13]
    end else if (xon_seen) begin
      s_d.xoff_hold = 1'b0; // see [R13]
    end
    s_d.dat = '0;
    if (req && !wb_we_i) begin
      unique case (wb_adr_i)
        {1'b0, UFI_ADR_FCTL}: s_d.dat = {24'h000000, s_q.fctl};
        {1'b0, UFI_ADR_ISTAT}: s_d.dat = {24'h000000, isr_val}; // see [R7]
        {1'b0, UFI_ADR_EFR}: s_d.dat = {24'h000000, s_q.enhanced_feature_reg};
        {1'b0, UFI_ADR_EVST}: s_d.dat = {25'h0000000, s_q.evst};
        UFI_ADR_EVMSK5: s_d.dat = {25'h0000000, s_q.evmsk};
        UFI_ADR_LVL: s_d.dat = {16'h0000, 2'b00, tx_trigger, 2'b00, rx_trigger};
        default: s_d.dat = '0;
      endcase
    end
    if (wr && wb_sel_i[0]) begin
      unique case (wb_adr_i)
        {1'b0, UFI_ADR_FCTL}: begin
          s_d.fctl[UFI_FEN_BIT] = wb_dat_i[UFI_FEN_BIT]; // see [R3]
          if (wb_dat_i[UFI_FEN_BIT]) begin
            s_d.fctl[7:2] = wb_dat_i[7:2]; // see [R4]
            s_d.rx_clr = wb_dat_i[UFI_RXRST_BIT]; // see [R1] see [R4]
          end
          s_d.fctl[UFI_RXRST_BIT] = 1'b0; // see [R2]
        end
        {1'b0, UFI_ADR_EFR}: s_d.enhanced_feature_reg = wb_dat_i[7:0];
        {1'b0, UFI_ADR_EVST}: s_d.evst = s_q.evst & ~wb_dat_i[UFI_NEV-1:0];
        UFI_ADR_EVMSK5: s_d.evmsk = wb_dat_i[UFI_NEV-1:0];
        default: ;
      endcase
    end
    // set wins over a clear in the same cycle
    s_d.evst = s_d.evst | ev_set;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
      s_q.fctl <= UFI_FCTL_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // control register: enable gate, self-clearing rx reset, one-cycle clear pulse

  chk_rxclr_pulse: assert property (@(posedge clock) disable iff (!arst_n) // see [R2]
    rx_fifo_clear
    |=> !rx_fifo_clear)
    else $error("rx clear not one cycle");

  chk_fctl_gate: assert property (@(posedge clock) disable iff (!arst_n) // see [R4]
    (wr && wb_sel_i[0] && wb_adr_i == {1'b0, UFI_ADR_FCTL} && !wb_dat_i[UFI_FEN_BIT])
    |=> $stable(s_q.fctl[7:2]) && !rx_fifo_clear)
    else $error("fctl written without enable");

  chk_fctl_load: assert property (@(posedge clock) disable iff (!arst_n) // see [R4]
    (wr && wb_sel_i[0] && wb_adr_i == {1'b0, UFI_ADR_FCTL} && wb_dat_i[UFI_FEN_BIT])
    |=> s_q.fctl[7:2] == $past(wb_dat_i[7:2]))
    else $error("fctl bits not loaded");

  chk_fen_write: assert property (@(posedge clock) disable iff (!arst_n) // see [R3]
    (wr && wb_sel_i[0] && wb_adr_i == {1'b0, UFI_ADR_FCTL})
    |=> fifo_enable == $past(wb_dat_i[UFI_FEN_BIT]))
    else $error("fifo enable not written");

  chk_rxclr_cause: assert property (@(posedge clock) disable iff (!arst_n) // see [R1]
    rx_fifo_clear
    |-> $past(wr) && $past(wb_dat_i[UFI_RXRST_BIT]))
    else $error("rx clear without request");

  chk_rxrst_zero: assert property (@(posedge clock) disable iff (!arst_n) // see [R2]
    s_q.fctl[UFI_RXRST_BIT]
    == 1'b0)
    else $error("rx reset bit stuck");

  // trigger decode, every code of both fields

  chk_rx_trig0: assert property (@(posedge clock) disable iff (!arst_n) // see [R5]
    s_q.fctl[7:6] == 2'b00
    |-> rx_trigger == LVL_W'(UFI_RX_TRIG0))
    else $error("rx trigger code wrong");

  chk_rx_trig1: assert property (@(posedge clock) disable iff (!arst_n) // see [R5]
    s_q.fctl[7:6] == 2'b01
    |-> rx_trigger == LVL_W'(UFI_RX_TRIG1))
    else $error("rx trigger code wrong");

  chk_rx_trig2: assert property (@(posedge clock) disable iff (!arst_n) // see [R5]
    s_q.fctl[7:6] == 2'b10
    |-> rx_trigger == LVL_W'(UFI_RX_TRIG2))
    else $error("rx trigger code wrong");

  chk_rx_trig: assert property (@(posedge clock) disable iff (!arst_n) // see [R5]
    s_q.fctl[7:6] == 2'b11
    |-> rx_trigger == LVL_W'(UFI_RX_TRIG3))
    else $error("rx trigger code wrong");

  chk_tx_trig0: assert property (@(posedge clock) disable iff (!arst_n) // see [R6]
    s_q.fctl[5:4] == 2'b00
    |-> tx_trigger == LVL_W'(UFI_TX_TRIG0))
    else $error("tx trigger code wrong");

  chk_tx_trig: assert property (@(posedge clock) disable iff (!arst_n) // see [R6]
    s_q.fctl[5:4] == 2'b01
    |-> tx_trigger == LVL_W'(UFI_TX_TRIG1))
    else $error("tx trigger code wrong");

  chk_tx_trig2: assert property (@(posedge clock) disable iff (!arst_n) // see [R6]
    s_q.fctl[5:4] == 2'b10
    |-> tx_trigger == LVL_W'(UFI_TX_TRIG2))
    else $error("tx trigger code wrong");

  chk_tx_trig3: assert property (@(posedge clock) disable iff (!arst_n) // see [R6]
    s_q.fctl[5:4] == 2'b11
    |-> tx_trigger == LVL_W'(UFI_TX_TRIG3))
    else $error("tx trigger code wrong");

  // level compares feeding the data and transmit sources

  chk_rx_hit: assert property (@(posedge clock) disable iff (!arst_n) // see [R16]
    fen && rx_level == rx_trigger
    |-> live[UFI_EV_RXD])
    else $error("rx trigger missed");

  chk_rx_nohit: assert property (@(posedge clock) disable iff (!arst_n) // see [R16]
    rx_level != rx_trigger
    |-> !live[UFI_EV_RXD])
    else $error("rx trigger false");

  chk_tx_low: assert property (@(posedge clock) disable iff (!arst_n) // see [R17]
    tx_level < tx_trigger
    |-> live[UFI_EV_THR])
    else $error("tx empty missed");

  chk_tx_high: assert property (@(posedge clock) disable iff (!arst_n) // see [R17]
    tx_level >= tx_trigger
    |-> !live[UFI_EV_THR])
    else $error("tx empty false");

  // status value: priority order and the code of each level

  chk_idle_bit: assert property (@(posedge clock) disable iff (!arst_n) // see [R15]
    interrupt_status[0]
    == (interrupt_status[5:1] == 5'h00 && !(|live)))
    else $error("idle bit wrong");

  chk_idle_zero: assert property (@(posedge clock) disable iff (!arst_n) // see [R18]
    !(|live)
    |-> interrupt_status[5:0] == 6'h01)
    else $error("idle status not clean");

  chk_top_bits: assert property (@(posedge clock) disable iff (!arst_n) // see [R11]
    interrupt_status[7:6]
    == {2{fifo_enable}})
    else $error("top bits wrong");

  chk_lsr_first: assert property (@(posedge clock) disable iff (!arst_n) // see [R8]
    line_status_source
    |-> interrupt_status[5:0] == UFI_CODE_LSR)
    else $error("line status not top");

  chk_code_rto: assert property (@(posedge clock) disable iff (!arst_n) // see [R9]
    live[UFI_EV_RTO] && !live[UFI_EV_LSR]
    |-> interrupt_status[5:0] == UFI_CODE_RTO)
    else $error("timeout code wrong");

  chk_code_rxd: assert property (@(posedge clock) disable iff (!arst_n) // see [R9]
    live[UFI_EV_RXD] && !live[UFI_EV_LSR] && !live[UFI_EV_RTO]
    |-> interrupt_status[5:0] == UFI_CODE_RXD)
    else $error("data ready code wrong");

  chk_code_thr: assert property (@(posedge clock) disable iff (!arst_n) // see [R9]
    live[UFI_EV_THR] && !live[UFI_EV_LSR] && !live[UFI_EV_RXD] && !live[UFI_EV_RTO]
    |-> interrupt_status[5:0] == UFI_CODE_THR)
    else $error("tx empty code wrong");

  chk_code_msr: assert property (@(posedge clock) disable iff (!arst_n) // see [R10]
    live[UFI_EV_MSR] && !(|live[UFI_EV_THR:UFI_EV_LSR])
    |-> interrupt_status[5:0] == UFI_CODE_MSR)
    else $error("modem code wrong");

  chk_code_xoff: assert property (@(posedge clock) disable iff (!arst_n) // see [R10]
    live[UFI_EV_XOFF] && !(|live[UFI_EV_MSR:UFI_EV_LSR])
    |-> interrupt_status[5:0] == UFI_CODE_XOFF)
    else $error("xoff code wrong");

  chk_code_flow: assert property (@(posedge clock) disable iff (!arst_n) // see [R10]
    live[UFI_EV_FLOW] && !(|live[UFI_EV_XOFF:UFI_EV_LSR])
    |-> interrupt_status[5:0] == UFI_CODE_FLOW)
    else $error("flow code wrong");

  chk_thr_hidden: assert property (@(posedge clock) disable iff (!arst_n) // see [R8]
    live[UFI_EV_LSR] && live[UFI_EV_THR]
    |-> interrupt_status[5:0] != UFI_CODE_THR)
    else $error("tx empty shown over line");

  chk_xoff_hidden: assert property (@(posedge clock) disable iff (!arst_n) // see [R8]
    live[UFI_EV_MSR] && live[UFI_EV_XOFF]
    |-> interrupt_status[4] == 1'b0)
    else $error("xoff shown over modem");

  chk_flow_hidden: assert property (@(posedge clock) disable iff (!arst_n) // see [R8]
    live[UFI_EV_XOFF] && live[UFI_EV_FLOW]
    |-> interrupt_status[5] == 1'b0)
    else $error("flow shown over xoff");

  // enhanced sources only count with the enhanced enable set

  chk_enh_bits: assert property (@(posedge clock) disable iff (!arst_n) // see [R12]
    !efen
    |-> interrupt_status[5:4] == 2'b00)
    else $error("enhanced bits leak");

  chk_enh_live: assert property (@(posedge clock) disable iff (!arst_n) // see [R12]
    !efen
    |-> !live[UFI_EV_XOFF] && !live[UFI_EV_FLOW])
    else $error("enhanced source live");

  chk_xoff_hold: assert property (@(posedge clock) disable iff (!arst_n) // see [R13]
    xoff_seen || (s_q.xoff_hold && !xon_seen)
    |=> s_q.xoff_hold)
    else $error("xoff not held");

  chk_xoff_clear: assert property (@(posedge clock) disable iff (!arst_n) // see [R13]
    xon_seen && !xoff_seen
    |=> !s_q.xoff_hold)
    else $error("xoff not released");

  chk_flow_sticky: assert property (@(posedge clock) disable iff (!arst_n) // see [R14]
    flow_event
    |=> s_q.evst[UFI_EV_FLOW])
    else $error("flow event lost");

  // bus side: registered ack, read data only while acked

  chk_ack_once: assert property (@(posedge clock) disable iff (!arst_n)
    wb_ack_o
    |=> !wb_ack_o)
    else $error("ack held two cycles");

  chk_ack_cause: assert property (@(posedge clock) disable iff (!arst_n)
    wb_ack_o
    |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");

  chk_dat_idle: assert property (@(posedge clock) disable iff (!arst_n)
    !wb_ack_o
    |-> wb_dat_o == 32'h00000000)
    else $error("read data outside ack");

endmodule // ufi_fifo_isr
`default_nettype wire

// ---- ufi_pkg.sv ----
// Purpose: shared constants and types for the fifo control / interrupt status block
// Assumes: classic wishbone, 32-bit data, one word per register
// Notes: offsets and status codes are named here once
`default_nettype none
package ufi_pkg;
  localparam logic [3:0] UFI_ADR_FCTL = 4'h0;
  localparam logic [3:0] UFI_ADR_ISTAT = 4'h4;
  localparam logic [3:0] UFI_ADR_EFR = 4'h8;
  localparam logic [3:0] UFI_ADR_EVST = 4'hC;
  localparam logic [3:0] UFI_ADR_EVMSK = 4'h0;
  localparam logic [4:0] UFI_ADR_EVMSK5 = 5'h10;
  localparam logic [4:0] UFI_ADR_LVL = 5'h14;
  localparam int UFI_FEN_BIT = 0;
  localparam int UFI_RXRST_BIT = 1;
  localparam int UFI_EFEN_BIT = 4;
  localparam logic [5:0] UFI_RX_TRIG0 = 6'h08;
  localparam logic [5:0] UFI_RX_TRIG1 = 6'h10;
  localparam logic [5:0] UFI_RX_TRIG2 = 6'h18;
  localparam logic [5:0] UFI_RX_TRIG3 = 6'h1C;
  localparam logic [5:0] UFI_TX_TRIG0 = 6'h10;
  localparam logic [5:0] UFI_TX_TRIG1 = 6'h08;
  localparam logic [5:0] UFI_TX_TRIG2 = 6'h18;
  localparam logic [5:0] UFI_TX_TRIG3 = 6'h1E;
  localparam logic [5:0] UFI_CODE_LSR = 6'h06;
  localparam logic [5:0] UFI_CODE_RXD = 6'h04;
  localparam logic [5:0] UFI_CODE_RTO = 6'h0C;
  localparam logic [5:0] UFI_CODE_THR = 6'h02;
  localparam logic [5:0] UFI_CODE_MSR = 6'h00;
  localparam logic [5:0] UFI_CODE_XOFF = 6'h10;
  localparam logic [5:0] UFI_CODE_FLOW = 6'h20;
  localparam logic [7:0] UFI_FCTL_RST = 8'h00;
  localparam int UFI_NEV = 7;
  // event bit order in status/mask registers
  typedef enum logic [2:0] {
    UFI_EV_LSR = 3'b000, UFI_EV_RXD = 3'b001, UFI_EV_RTO = 3'b010,
    UFI_EV_THR = 3'b011, UFI_EV_MSR = 3'b100, UFI_EV_XOFF = 3'b101,
    UFI_EV_FLOW = 3'b110
  } ufi_ev_t;
  typedef struct packed {
    logic [7:0] fctl;
    logic [7:0] enhanced_feature_reg;
    logic [UFI_NEV-1:0] evst;
    logic [UFI_NEV-1:0] evmsk;
    logic xoff_hold;
    logic rx_clr;
    logic ack;
    logic [31:0] dat;
  } ufi_state_t;
endpackage : ufi_pkg
`default_nettype wire

// ---- ufi_fifo_model.sv ----
// Purpose: occupancy model of the channel fifos beside the status block
// Assumes: bench loads levels by a one-cycle strobe
// Notes: a clear from the block wins over a load in the same cycle
`default_nettype none
module ufi_fifo_model #(
  parameter int W = 6
) (
  input wire logic clock, // system clock
  input wire logic arst_n, // async reset, active low
  input wire logic ld, // load strobe from bench
  input wire logic [W-1:0] ld_rx, // rx level to load
  input wire logic [W-1:0] ld_tx, // tx level to load
  input wire logic rx_fifo_clear, // clear from block
  output logic [W-1:0] rx_level, // rx occupancy
  output logic [W-1:0] tx_level // tx occupancy
);
  timeunit 1ns;
  timeprecision 1ps;
  // tx starts full so no transmit event fires before the bench asks
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rx_level <= '0;
      tx_level <= '1;
    end else if (rx_fifo_clear) begin
      rx_level <= '0;
    end else if (ld) begin
      rx_level <= ld_rx;
      tx_level <= ld_tx;
    end
  end
endmodule // ufi_fifo_model
`default_nettype wire

// ---- ufi_fifo_isr_tb.sv ----
// Purpose: bus-level test of fifo control and interrupt status
// Assumes: event mask open while status is read
// Notes: inputs change by non-blocking assignment after a rising edge
`default_nettype none
module ufi_fifo_isr_tb
  import ufi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 0, arst_n = 0, cyc = 0, we = 0, ldv = 0;
  logic line = 0, tmo = 0, mdm = 0, ack, fen, clr, irq;
  logic [2:0] pl = '0; // xoff, xon, flow pulses
  logic [4:0] adr = '0;
  logic [31:0] dat = '0, rdq, dat_o;
  logic [5:0] lr = '0, lt = '0, rxl, txl, rxt, txt;
  logic [7:0] ist;
  int mismatches = 0, checks = 0, cyc_n = 0;
  logic [5:0] rtab[4] = '{UFI_RX_TRIG0, UFI_RX_TRIG1, UFI_RX_TRIG2, UFI_RX_TRIG3};
  logic [5:0] ttab[4] = '{UFI_TX_TRIG0, UFI_TX_TRIG1, UFI_TX_TRIG2, UFI_TX_TRIG3};
  logic [5:0] code[7] = '{UFI_CODE_LSR, UFI_CODE_RTO, UFI_CODE_RXD, UFI_CODE_THR,
    UFI_CODE_MSR, UFI_CODE_XOFF, UFI_CODE_FLOW};
  int evb[7] = '{0, 2, 1, 3, 4, 5, 6};
  always #4 clock = ~clock;
  ufi_fifo_isr u_ufi_fifo_isr (.clock(clock), .arst_n(arst_n), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .rx_level(rxl), .tx_level(txl),
    .line_status_source(line), .rx_timeout(tmo), .modem_status_source(mdm),
    .xoff_seen(pl[0]), .xon_seen(pl[1]), .flow_event(pl[2]), .fifo_enable(fen),
    .rx_fifo_clear(clr), .rx_trigger(rxt), .tx_trigger(txt),
    .interrupt_status(ist), .irq(irq));
  ufi_fifo_model u_ufi_fifo_model (.clock(clock), .arst_n(arst_n), .ld(ldv),
    .ld_rx(lr), .ld_tx(lt), .rx_fifo_clear(clr), .rx_level(rxl), .tx_level(txl));
  task automatic test_done;
    if (mismatches == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // classic cycle: hold everything until ack is sampled high
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clock);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) mismatches++;
    rdq = dat_o;
    cyc <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rdq, e);
  endtask
  task automatic pulse(input int k);
    @(posedge clock);
    pl[k] <= 1'b1;
    @(posedge clock);
    pl[k] <= 1'b0;
  endtask
  task automatic ld(input logic [5:0] r, input logic [5:0] t);
    @(posedge clock);
    ldv <= 1'b1;
    lr <= r;
    lt <= t;
    @(posedge clock);
    ldv <= 1'b0;
  endtask
  // irq is combinational from registers, so let two edges pass
  task automatic irq_is(input logic e);
    repeat (2) @(negedge clock);
    chk(32'(irq), 32'(e));
  endtask
  always @(posedge clock) begin
    cyc_n++;
    if (cyc_n == 3000) begin
      mismatches++;
      test_done;
    end
  end
  initial begin
    repeat (9) @(posedge clock);
    @(negedge clock);
    chk(32'(ist), 32'h01);
    @(posedge clock);
    arst_n <= 1'b1;
    wr(5'(UFI_ADR_FCTL), 32'hF0);
    chk(32'(fen), 32'h0);
    rd(UFI_ADR_LVL, {18'h0, ttab[0], 2'h0, rtab[0]});
    for (int i = 0; i < 4; i++) begin
      wr(5'(UFI_ADR_FCTL), {24'h0, 2'(i), 2'(3 - i), 4'h1});
      rd(UFI_ADR_LVL, {18'h0, ttab[3 - i], 2'h0, rtab[i]});
      chk(32'(fen), 32'h1);
      chk(32'(ist[7:6]), 32'h3);
    end
    rd(5'h18, 32'h0);
    ld(6'h05, 6'h1F);
    wr(5'(UFI_ADR_FCTL), 32'h02);
    repeat (3) @(posedge clock);
    chk(32'(rxl), 32'h05);
    wr(5'(UFI_ADR_FCTL), 32'h03);
    repeat (3) @(posedge clock);
    chk(32'(rxl), 32'h00);
    rd(5'(UFI_ADR_FCTL), 32'h01);
    wr(5'(UFI_ADR_EFR), 32'h10);
    wr(UFI_ADR_EVMSK5, 32'h7F);
    ld(6'h08, 6'h00);
    line <= 1'b1;
    tmo <= 1'b1;
    mdm <= 1'b1;
    pulse(0);
    pulse(2);
    irq_is(1'b1);
    wr(UFI_ADR_EVMSK5, 32'h00);
    irq_is(1'b0);
    wr(UFI_ADR_EVMSK5, 32'h7F);
    // service sources from the top, one per pass
    for (int i = 0; i < 7; i++) begin
      rd(5'(UFI_ADR_ISTAT), {24'h0, 2'h3, code[i]});
      case (i)
        0: line <= 1'b0;
        1: tmo <= 1'b0;
        2: ld(6'h00, 6'h00);
        3: ld(6'h00, 6'h1F);
        4: mdm <= 1'b0;
        5: pulse(1);
        default: ;
      endcase
      wr(5'(UFI_ADR_EVST), 32'h1 << evb[i]);
    end
    rd(5'(UFI_ADR_ISTAT), 32'hC1);
    irq_is(1'b0);
    wr(5'(UFI_ADR_EFR), 32'h00);
    pulse(2);
    bus(1'b0, 5'(UFI_ADR_ISTAT), 32'h0);
    chk(32'(rdq[5:4]), 32'h0);
    test_done;
  end
endmodule // ufi_fifo_isr_tb
`default_nettype wire
